//--- bxalu_core.sv
// Byte datapath for subtract, rotates, nibble swap, exclusive-OR and direction load.
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bxalu_core
  import bxalu_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_valid,
  input  wire bxalu_op_t   i_op,
  input  wire logic        i_dest,
  input  wire logic [4:0]  i_fsel,
  input  wire logic [7:0]  i_freg,
  input  wire logic [7:0]  i_lit,
  output logic [7:0]       o_acc,
  output logic             o_carry,
  output logic             o_nibble_overflow_flag,
  output logic             o_null_result_flag,
  output logic             o_fwr_en,
  output logic [4:0]       o_fwr_sel,
  output logic [7:0]       o_fwr_data,
  output logic [15:0]      o_pin_dir
);
  logic [7:0] acc_q, acc_d;
  logic       c_q, c_d, dc_q, dc_d, z_q, z_d;
  logic       fwe_q, fwe_d;
  logic [4:0] fsel_q, fsel_d;
  logic [7:0] fdat_q, fdat_d;
  logic [7:0] dir_q [BXALU_NDIR];
  logic [7:0] dir_d [BXALU_NDIR];
  logic [8:0] diff;
  logic [4:0] ndiff;
  logic [7:0] res;
  logic       to_dest;

  always_comb begin
    acc_d  = acc_q;
    c_d    = c_q;
    dc_d   = dc_q;
    z_d    = z_q;
    fwe_d  = 1'b0;
    fsel_d = i_fsel;
    fdat_d = fdat_q;
    res    = 8'h00;
    to_dest = 1'b0;
    // Borrow-free carry: carry set means no borrow, as the two's complement sum gives.
    diff  = {1'b0, i_freg} + {1'b0, ~acc_q} + 9'h001;
    ndiff = {1'b0, i_freg[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;
    if (i_valid) begin
      case (i_op)
        BXALU_OP_SUB: begin
          res = diff[7:0];
          c_d = diff[8];
          dc_d = ndiff[4];
          z_d = (diff[7:0] == 8'h00);
          to_dest = 1'b1;
        end
        BXALU_OP_RRC: begin
          res = {c_q, i_freg[7:1]};
          c_d = i_freg[0];
          to_dest = 1'b1;
        end
        BXALU_OP_RLC: begin
          res = {i_freg[6:0], c_q};
          c_d = i_freg[7];
          to_dest = 1'b1;
        end
        BXALU_OP_SWAP: begin
          res = {i_freg[3:0], i_freg[7:4]};
          to_dest = 1'b1;
        end
        BXALU_OP_XORF: begin
          res = acc_q ^ i_freg;
          z_d = (res == 8'h00);
          to_dest = 1'b1;
        end
        BXALU_OP_XORK: begin
          acc_d = acc_q ^ i_lit;
          z_d = ((acc_q ^ i_lit) == 8'h00);
        end
        default: begin
        end
      endcase
      if (to_dest) begin
        // The destination bit low keeps the result in the accumulator.
        if (i_dest) begin
          fwe_d  = 1'b1;
          fdat_d = res;
        end else begin
          acc_d = res;
        end
      end
    end
  end

  genvar g;
  for (g = 0; g < BXALU_NDIR; g++) begin : g_dir
    always_comb begin
      dir_d[g] = dir_q[g];
      // Any other operand value is ignored so stray encodings cannot corrupt pin direction.
      if (i_valid && i_op == BXALU_OP_DIR && i_fsel == BXALU_DIR_SEL_LO + 5'(g)) begin
        dir_d[g] = acc_q;
      end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        dir_q[g] <= BXALU_DIR_RST;
      end else begin
        dir_q[g] <= dir_d[g];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_q  <= BXALU_ACC_RST;
      c_q    <= BXALU_FLAG_RST;
      dc_q   <= BXALU_FLAG_RST;
      z_q    <= BXALU_FLAG_RST;
      fwe_q  <= BXALU_FWE_RST;
      fsel_q <= BXALU_FSEL_RST;
      fdat_q <= BXALU_FDAT_RST;
    end else begin
      acc_q  <= acc_d;
      c_q    <= c_d;
      dc_q   <= dc_d;
      z_q    <= z_d;
      fwe_q  <= fwe_d;
      fsel_q <= fsel_d;
      fdat_q <= fdat_d;
    end
  end

  assign o_acc = acc_q;
  assign o_carry = c_q;
  assign o_nibble_overflow_flag = dc_q;
  assign o_null_result_flag = z_q;
  assign o_fwr_en = fwe_q;
  assign o_fwr_sel = fsel_q;
  assign o_fwr_data = fdat_q;
  assign o_pin_dir = {dir_q[1], dir_q[0]};

  chk_sub_result: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_SUB && !i_dest |=> acc_q == 8'($past(i_freg) - $past(acc_q)))
    else $error("Subtract result wrong.");
  chk_sub_carry: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_SUB |=> c_q == ($past(i_freg) >= $past(acc_q)))
    else $error("Subtract carry wrong.");
  chk_rrc_value: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_RRC && i_dest
    |=> fwe_q && fdat_q == {$past(c_q), $past(i_freg[7:1])} && c_q == $past(i_freg[0]))
    else $error("Rotate right wrong.");
  chk_rlc_value: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_RLC && !i_dest
    |=> acc_q == {$past(i_freg[6:0]), $past(c_q)} && c_q == $past(i_freg[7]) && $stable(z_q))
    else $error("Rotate left wrong.");
  chk_swap_flags: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_SWAP |=> $stable(c_q) && $stable(z_q) && $stable(dc_q))
    else $error("Nibble exchange changed a flag.");
  chk_dir_load: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_DIR && i_fsel == BXALU_DIR_SEL_HI
    |=> dir_q[1] == $past(acc_q) && $stable(c_q) && $stable(z_q))
    else $error("Direction load wrong.");
  chk_xorf_dest: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_XORF && i_dest
    |=> fwe_q && fdat_q == ($past(acc_q) ^ $past(i_freg)) && $stable(acc_q))
    else $error("Register exclusive-OR wrong.");
  chk_xork_zero: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_XORK
    |=> acc_q == ($past(acc_q) ^ $past(i_lit)) && z_q == (acc_q == 8'h00))
    else $error("Literal exclusive-OR wrong.");

  chk_sub_dest_reg: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_SUB && i_dest
    |=> fwe_q && fdat_q == 8'($past(i_freg) - $past(acc_q)) && $stable(acc_q))
    else $error("Subtract to register wrong.");

  chk_sub_to_acc: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_SUB && !i_dest
    |=> !fwe_q)
    else $error("Subtract to accumulator wrote a register.");

  chk_sub_nibble: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_SUB
    |=> dc_q == ($past(i_freg[3:0]) >= $past(acc_q[3:0])))
    else $error("Subtract nibble flag wrong.");

  chk_sub_null: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_SUB
    |=> z_q == ($past(i_freg) == $past(acc_q)))
    else $error("Subtract zero flag wrong.");

  chk_dc_sub_only: assert property (@(posedge i_clk) disable iff (i_rst)
    !(i_valid && i_op == BXALU_OP_SUB)
    |=> $stable(dc_q))
    else $error("Nibble flag changed outside subtract.");

  chk_rrc_to_acc: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_RRC && !i_dest
    |=> !fwe_q && acc_q == {$past(c_q), $past(i_freg[7:1])})
    else $error("Rotate right to accumulator wrong.");

  chk_rrc_keep_acc: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_RRC && i_dest
    |=> $stable(acc_q))
    else $error("Rotate right to register changed the accumulator.");

  chk_rrc_flags: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_RRC
    |=> $stable(z_q) && $stable(dc_q) && c_q == $past(i_freg[0]))
    else $error("Rotate right flags wrong.");

  chk_carry_sources: assert property (@(posedge i_clk) disable iff (i_rst)
    !(i_valid && (i_op == BXALU_OP_SUB || i_op == BXALU_OP_RRC
                  || i_op == BXALU_OP_RLC))
    |=> $stable(c_q))
    else $error("Carry changed by an instruction that keeps it.");

  chk_rlc_dest_reg: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_RLC && i_dest
    |=> fwe_q && fdat_q == {$past(i_freg[6:0]), $past(c_q)} && $stable(acc_q))
    else $error("Rotate left to register wrong.");

  chk_rlc_flags: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_RLC
    |=> $stable(z_q) && $stable(dc_q) && c_q == $past(i_freg[7]))
    else $error("Rotate left flags wrong.");

  chk_rlc_to_acc: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_RLC && !i_dest
    |=> !fwe_q)
    else $error("Rotate left to accumulator wrote a register.");

  chk_swap_to_acc: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_SWAP && !i_dest
    |=> !fwe_q && acc_q == {$past(i_freg[3:0]), $past(i_freg[7:4])})
    else $error("Nibble exchange to accumulator wrong.");

  chk_swap_dest_reg: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_SWAP && i_dest
    |=> fwe_q && fdat_q == {$past(i_freg[3:0]), $past(i_freg[7:4])} && $stable(acc_q))
    else $error("Nibble exchange to register wrong.");

  chk_dir_lo_load: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_DIR && i_fsel == BXALU_DIR_SEL_LO
    |=> dir_q[0] == $past(acc_q) && $stable(dir_q[1]))
    else $error("Low direction load wrong.");

  chk_dir_hi_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_DIR && i_fsel == BXALU_DIR_SEL_HI
    |=> $stable(dir_q[0]))
    else $error("High direction load touched the low register.");

  chk_dir_no_side: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_DIR
    |=> $stable(dc_q) && $stable(acc_q) && !fwe_q)
    else $error("Direction load had a side effect.");

  chk_dir_stray: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_DIR
    && i_fsel != BXALU_DIR_SEL_LO && i_fsel != BXALU_DIR_SEL_HI
    |=> $stable(dir_q[0]) && $stable(dir_q[1]))
    else $error("Direction load with a stray operand took effect.");

  chk_dir_only_op: assert property (@(posedge i_clk) disable iff (i_rst)
    !(i_valid && i_op == BXALU_OP_DIR)
    |=> $stable(dir_q[0]) && $stable(dir_q[1]))
    else $error("Pin direction changed outside a direction load.");

  chk_xorf_to_acc: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_XORF && !i_dest
    |=> !fwe_q && acc_q == ($past(acc_q) ^ $past(i_freg)))
    else $error("Register exclusive-OR to accumulator wrong.");

  chk_xorf_flags: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_XORF
    |=> $stable(c_q) && $stable(dc_q))
    else $error("Register exclusive-OR changed carry or nibble flag.");

  chk_xorf_null: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_XORF
    |=> z_q == ($past(acc_q) == $past(i_freg)))
    else $error("Register exclusive-OR zero flag wrong.");

  chk_xork_flags: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_XORK
    |=> $stable(c_q) && $stable(dc_q) && !fwe_q)
    else $error("Literal exclusive-OR had a side effect.");

  chk_xork_null: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_op == BXALU_OP_XORK
    |=> z_q == ($past(acc_q) == $past(i_lit)))
    else $error("Literal exclusive-OR zero flag wrong.");

  chk_null_sources: assert property (@(posedge i_clk) disable iff (i_rst)
    !(i_valid && (i_op == BXALU_OP_SUB || i_op == BXALU_OP_XORF
                  || i_op == BXALU_OP_XORK))
    |=> $stable(z_q))
    else $error("Zero flag changed by an instruction that keeps it.");

  chk_idle_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_valid
    |=> $stable(acc_q) && $stable(c_q) && $stable(dc_q) && $stable(z_q))
    else $error("State changed with no instruction.");

  chk_fwr_cause: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_valid
    |=> !fwe_q)
    else $error("Register write with no instruction.");

  chk_fsel_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    i_valid && i_dest
    |=> fsel_q == $past(i_fsel))
    else $error("Register write select wrong.");
endmodule
`default_nettype wire

//--- bxalu_pkg.sv
// Constants and opcode enumeration for the byte datapath.
package bxalu_pkg;
  localparam int unsigned BXALU_W = 8;
  localparam logic [7:0] BXALU_ACC_RST = 8'h00;
  localparam logic [7:0] BXALU_DIR_RST = 8'hff;
  localparam logic       BXALU_FLAG_RST = 1'b0;
  localparam logic       BXALU_FWE_RST = 1'b0;
  localparam logic [4:0] BXALU_FSEL_RST = 5'h00;
  localparam logic [7:0] BXALU_FDAT_RST = 8'h00;
  localparam logic [4:0] BXALU_DIR_SEL_LO = 5'h06;
  localparam logic [4:0] BXALU_DIR_SEL_HI = 5'h07;
  localparam int unsigned BXALU_NDIR = 2;
  typedef enum logic [2:0] {
    BXALU_OP_NONE,
    BXALU_OP_SUB,
    BXALU_OP_RRC,
    BXALU_OP_RLC,
    BXALU_OP_SWAP,
    BXALU_OP_DIR,
    BXALU_OP_XORF,
    BXALU_OP_XORK
  } bxalu_op_t;
endpackage

//--- tb.sv
// Self-checking testbench for the byte datapath.
`timescale 1ns/1ps
`default_nettype none
module tb
  import bxalu_pkg::*;
;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic       i_valid = 1'b0;
  bxalu_op_t  i_op = BXALU_OP_NONE;
  logic       i_dest = 1'b0;
  logic [4:0] i_fsel = 5'h00;
  logic [7:0] i_freg = 8'h00;
  logic [7:0] i_lit = 8'h00;
  logic [7:0] o_acc, o_fwr_data;
  logic [4:0] o_fwr_sel;
  logic [15:0] o_pin_dir;
  logic       o_carry, o_nibble_overflow_flag, o_null_result_flag, o_fwr_en;
  int         miscompares = 0;
  int         check_count = 0;
  wire logic [2:0] flg = {o_carry, o_nibble_overflow_flag, o_null_result_flag};
  bxalu_core u_bxalu_core (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid), .i_op(i_op),
    .i_dest(i_dest), .i_fsel(i_fsel), .i_freg(i_freg), .i_lit(i_lit), .o_acc(o_acc),
    .o_carry(o_carry), .o_nibble_overflow_flag(o_nibble_overflow_flag),
    .o_null_result_flag(o_null_result_flag), .o_fwr_en(o_fwr_en), .o_fwr_sel(o_fwr_sel),
    .o_fwr_data(o_fwr_data), .o_pin_dir(o_pin_dir));
  always #5 i_clk = ~i_clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic ck(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One instruction; outputs are sampled just after the edge that takes it.
  task automatic go(input bxalu_op_t op, input logic d, input logic [4:0] s,
                    input logic [7:0] f, input logic [7:0] k);
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_op <= op;
    i_dest <= d;
    i_fsel <= s;
    i_freg <= f;
    i_lit <= k;
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
  endtask
  task automatic t_xork();
    go(BXALU_OP_XORK, 1'b1, 5'h01, 8'h00, 8'hff);
    ck({o_acc, 5'h00, flg}, 16'hff00);
    go(BXALU_OP_XORK, 1'b0, 5'h01, 8'h00, 8'hfc);
    ck({o_acc, 5'h00, flg}, 16'h0300);
  endtask
  task automatic t_sub();
    go(BXALU_OP_SUB, 1'b1, 5'h09, 8'h05, 8'h00);
    ck({2'b00, o_fwr_en, o_fwr_sel, o_fwr_data}, 16'h2902);
    ck({o_acc, 5'h00, flg}, 16'h0306);
    go(BXALU_OP_SUB, 1'b0, 5'h09, 8'h03, 8'h00);
    ck({o_fwr_en, o_acc, 4'h0, flg}, 16'h0007);
    go(BXALU_OP_XORK, 1'b0, 5'h00, 8'h00, 8'h01);
    go(BXALU_OP_SUB, 1'b0, 5'h00, 8'h00, 8'h00);
    ck({o_acc, 5'h00, flg}, 16'hff00);
  endtask
  task automatic t_rot();
    go(BXALU_OP_RRC, 1'b1, 5'h0a, 8'h01, 8'h00);
    ck({o_fwr_en, o_fwr_data, 4'h0, flg}, 16'h8004);
    @(posedge i_clk);
    #1;
    ck({o_fwr_en, o_fwr_data, 4'h0, flg}, 16'h0004);
    go(BXALU_OP_RLC, 1'b0, 5'h0a, 8'h80, 8'h00);
    ck({o_acc, 5'h00, flg}, 16'h0104);
    go(BXALU_OP_RRC, 1'b0, 5'h0a, 8'h02, 8'h00);
    ck({o_acc, 5'h00, flg}, 16'h8100);
    go(BXALU_OP_RLC, 1'b1, 5'h0a, 8'hc0, 8'h00);
    ck({o_fwr_en, o_fwr_data, o_acc[6:0]}, 16'hc001);
  endtask
  task automatic t_misc();
    go(BXALU_OP_SWAP, 1'b0, 5'h0b, 8'ha5, 8'h00);
    ck({o_acc, 5'h00, flg}, 16'h5a04);
    go(BXALU_OP_SWAP, 1'b1, 5'h0b, 8'h3c, 8'h00);
    ck({o_fwr_en, o_fwr_data, o_acc[6:0]}, 16'he1da);
    go(BXALU_OP_DIR, 1'b0, 5'h06, 8'h00, 8'h00);
    go(BXALU_OP_DIR, 1'b0, 5'h05, 8'h00, 8'h00);
    ck(o_pin_dir, 16'hff5a);
    go(BXALU_OP_DIR, 1'b0, 5'h07, 8'h00, 8'h00);
    ck({o_pin_dir[15:8], 5'h00, flg}, 16'h5a04);
    go(BXALU_OP_XORF, 1'b1, 5'h0c, 8'h5a, 8'h00);
    ck({o_fwr_en, o_fwr_data, o_acc[6:0]}, 16'h805a);
    ck({13'h0000, flg}, 16'h0005);
    go(BXALU_OP_XORF, 1'b0, 5'h0c, 8'h0f, 8'h00);
    ck({o_acc, 5'h00, flg}, 16'h5504);
  endtask
  initial begin
    #20000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    ck({o_acc, o_fwr_en, 4'h0, flg}, 16'h0000);
    ck(o_pin_dir, 16'hffff);
    t_xork();
    t_sub();
    t_rot();
    t_misc();
    close_out();
  end
endmodule
`default_nettype wire
